// >>> logic/mdia_device.sv
// Notes on behaviour
// - direct mode: group done sets flag, pin low
// - auto mode: 2us low pulse per pass
// - global alarm low while any alarm flag set
// - external convert rising edge starts conversion
// - load strobe updates enabled DACs together
// - pins 4,5 plain I/O; 0-3 dual purpose
// - select 0 alarm output, 1 general I/O
// - state 1 releases pin, 0 drives low
// - input pin reads present pin level
// - reset: all pins general I/O, released
// - alarms cover first four sequence positions only
// - flag set when input leaves window
// - host keeps high threshold above low one
// - host disables alarm via default thresholds
// - alarm pin and readback show complement
// - auto mode: alarms change only at pulse
// - direct mode: alarms hold until clean conversion
// - new subset without offender clears alarm
// - reset clears alarms and all state
// - host holds load strobe low at power-up
// - host powers up needed blocks after reset
// - flag cleared by read, start, zero write
// - external trigger: one direct pass per edge
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
module mdia_device #(
  parameter int PINS = mdia_pkg::GPIO_PINS,
  parameter int ALARMS = mdia_pkg::ALARM_CH,
  parameter int DW = mdia_pkg::DATA_W,
  parameter int DACS = mdia_pkg::DAC_CH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  mdia_if.device link,
  input wire logic soft_reset,
  input wire logic mode_auto,
  input wire logic ext_trigger_en,
  input wire logic start_cmd,
  input wire logic res_valid,
  input wire logic [mdia_pkg::POS_W-1:0] res_pos,
  input wire logic [DW-1:0] res_data,
  input wire logic group_done,
  input wire logic [ALARMS*DW-1:0] upper_bound_reg,
  input wire logic [ALARMS*DW-1:0] lower_bound,
  input wire logic data_read,
  input wire logic flag_clear,
  input wire logic gpio_wr,
  input wire logic [ALARMS-1:0] wr_function_sel,
  input wire logic [PINS-1:0] wr_state,
  input wire logic [DACS-1:0] sync_load_en,
  output logic conv_start,
  output logic conv_done_flag,
  output logic [ALARMS-1:0] alarm_flag,
  output logic [ALARMS-1:0] pin_function_sel,
  output logic [PINS-1:0] pin_state_bit,
  output logic [DACS-1:0] dac_load
);
  localparam logic [mdia_pkg::DAV_CNT_W-1:0] PULSE_LAST =
    mdia_pkg::DAV_CNT_W'(mdia_pkg::DAV_PULSE_CYC - 1);
  localparam logic [PINS-1:0] PIN_ALL_ONES = '1;

  if (ALARMS > PINS || ALARMS < 1) begin : g_chk_alarms
    $error("alarm count must lie between 1 and the pin count");
  end
  if (mdia_pkg::DAV_PULSE_CYC >= (1 << mdia_pkg::DAV_CNT_W)) begin : g_chk_cnt
    $error("pulse counter too narrow");
  end
  if ((1 << mdia_pkg::POS_W) < ALARMS) begin : g_chk_pos
    $error("position field too narrow");
  end

  // synchronisers and edge history
  logic [1:0] conv_sync_reg;
  logic [1:0] load_sync_reg;
  logic conv_prev_reg;
  logic load_prev_reg;
  logic [PINS-1:0] gpio_s1_reg;
  logic [PINS-1:0] gpio_s2_reg;

  logic conv_start_reg;
  logic conv_done_reg;
  logic conv_done_next;
  logic data_valid_n_reg;
  logic data_valid_n_next;
  logic global_alarm_n_reg;
  logic [ALARMS-1:0] pend_reg;
  logic [ALARMS-1:0] pend_next;
  logic [ALARMS-1:0] alarm_reg;
  logic [ALARMS-1:0] alarm_next;
  logic [ALARMS-1:0] func_reg;
  logic [PINS-1:0] drive_reg;
  logic [PINS-1:0] oe_reg;
  logic [PINS-1:0] oe_next;
  logic [PINS-1:0] state_reg;
  logic [PINS-1:0] state_next;
  logic [DACS-1:0] dac_load_reg;
  mdia_pkg::mdia_dav_t dav_state_reg;
  mdia_pkg::mdia_dav_t dav_state_next;
  logic [mdia_pkg::DAV_CNT_W-1:0] dav_cnt_reg;
  logic [mdia_pkg::DAV_CNT_W-1:0] dav_cnt_next;

  wire clr = ~aresetn | soft_reset;
  wire conv_rise = conv_sync_reg[1] & ~conv_prev_reg;
  wire load_rise = load_sync_reg[1] & ~load_prev_reg;
  // external trigger forces direct mode
  wire auto_mode = mode_auto & ~ext_trigger_en;
  wire start_evt = ext_trigger_en ? conv_rise : start_cmd;
  wire [ALARMS-1:0] out_of_window;

  // per-position window comparison, index is sequence position
  for (genvar g = 0; g < ALARMS; g++) begin : g_win
    wire [DW-1:0] hi = upper_bound_reg[g*DW +: DW];
    wire [DW-1:0] lo = lower_bound[g*DW +: DW];
    // inverted window (hi below lo) flags every sample
    assign out_of_window[g] = (res_data > hi) | (res_data < lo);
    // pass start forgets old results, so a subset drops its offenders
    assign pend_next[g] = start_evt ? 1'b0 :
                          (res_valid && res_pos == mdia_pkg::POS_W'(g)) ? out_of_window[g] :
                          pend_reg[g];
  end

  // alarms only change at the end of a pass
  assign alarm_next = group_done ? pend_reg : alarm_reg;

  // set on group done wins over any clear in the same cycle
  assign conv_done_next = auto_mode ? 1'b0 :
                          group_done ? 1'b1 :
                          (data_read | start_evt | flag_clear) ? 1'b0 :
                          conv_done_reg;

  always_comb begin
    dav_state_next = dav_state_reg;
    dav_cnt_next = dav_cnt_reg;
    case (dav_state_reg)
      mdia_pkg::MDIA_DAV_IDLE: begin
        if (auto_mode && group_done) begin
          dav_state_next = mdia_pkg::MDIA_DAV_PULSE;
          dav_cnt_next = PULSE_LAST;
        end
      end
      mdia_pkg::MDIA_DAV_PULSE: begin
        if (auto_mode && group_done) begin
          dav_cnt_next = PULSE_LAST;
        end else if (!auto_mode || dav_cnt_reg == '0) begin
          dav_state_next = mdia_pkg::MDIA_DAV_IDLE;
        end else begin
          dav_cnt_next = dav_cnt_reg - 1'b1;
        end
      end
      default: begin
        dav_state_next = mdia_pkg::MDIA_DAV_IDLE;
        dav_cnt_next = '0;
      end
    endcase
  end

  assign data_valid_n_next = auto_mode ? (dav_state_next != mdia_pkg::MDIA_DAV_PULSE) :
                             ~conv_done_next;

  // pin drive and readback
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    if (p < ALARMS) begin : g_dual
      wire alarm_fn = ~func_reg[p];
      // alarm pin pulls low while its flag is set
      assign oe_next[p] = alarm_fn ? alarm_next[p] : ~drive_reg[p];
      assign state_next[p] = alarm_fn ? ~alarm_reg[p] : gpio_s2_reg[p];
    end else begin : g_plain
      assign oe_next[p] = ~drive_reg[p];
      assign state_next[p] = gpio_s2_reg[p];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_sync_reg <= 2'h0;
      load_sync_reg <= 2'h0;
      conv_prev_reg <= 1'b0;
      load_prev_reg <= 1'b0;
      gpio_s1_reg <= PIN_ALL_ONES;
      gpio_s2_reg <= PIN_ALL_ONES;
    end else if (ce) begin
      conv_sync_reg <= {conv_sync_reg[0], link.convert};
      load_sync_reg <= {load_sync_reg[0], link.ext_dac_load};
      conv_prev_reg <= conv_sync_reg[1];
      load_prev_reg <= load_sync_reg[1];
      gpio_s1_reg <= link.gpio_level;
      gpio_s2_reg <= gpio_s1_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      conv_start_reg <= 1'b0;
      conv_done_reg <= 1'b0;
      data_valid_n_reg <= 1'b1;
      global_alarm_n_reg <= 1'b1;
      pend_reg <= '0;
      alarm_reg <= '0;
      func_reg <= mdia_pkg::PIN_FUNC_RST;
      drive_reg <= mdia_pkg::PIN_STATE_RST;
      oe_reg <= '0;
      state_reg <= mdia_pkg::PIN_STATE_RST;
      dac_load_reg <= '0;
      dav_state_reg <= mdia_pkg::MDIA_DAV_IDLE;
      dav_cnt_reg <= '0;
    end else if (ce) begin
      conv_start_reg <= start_evt;
      conv_done_reg <= conv_done_next;
      data_valid_n_reg <= data_valid_n_next;
      global_alarm_n_reg <= ~(|alarm_next);
      pend_reg <= pend_next;
      alarm_reg <= alarm_next;
      if (gpio_wr) begin
        func_reg <= wr_function_sel;
        drive_reg <= wr_state;
      end
      oe_reg <= oe_next;
      state_reg <= state_next;
      dac_load_reg <= load_rise ? sync_load_en : '0;
      dav_state_reg <= dav_state_next;
      dav_cnt_reg <= dav_cnt_next;
    end
  end

  assign link.data_valid_n = data_valid_n_reg;
  assign link.global_alarm_n = global_alarm_n_reg;
  assign link.dev_gpio_o = '0;
  assign link.dev_gpio_oe = oe_reg;
  assign conv_start = conv_start_reg;
  assign conv_done_flag = conv_done_reg;
  assign alarm_flag = alarm_reg;
  assign pin_function_sel = func_reg;
  assign pin_state_bit = state_reg;
  assign dac_load = dac_load_reg;
endmodule
`default_nettype wire

// >>> logic/mdia_pkg.sv
`default_nettype none
package mdia_pkg;
  // pin and channel counts
  localparam int GPIO_PINS = 6;
  localparam int ALARM_CH = 4;
  localparam int DATA_W = 12;
  localparam int DAC_CH = 8;
  localparam int POS_W = 4;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DAV_PULSE_NS = 2000;
  localparam int DAV_PULSE_CYC = (DAV_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int DAV_CNT_W = 9;
  // reset values of the pin configuration
  localparam logic [GPIO_PINS-1:0] PIN_STATE_RST = 6'h3f;
  localparam logic [ALARM_CH-1:0] PIN_FUNC_RST = 4'hf;
  // host controller register map
  localparam int HOST_ADDR_W = 8;
  localparam logic [HOST_ADDR_W-1:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [HOST_ADDR_W-1:0] HOST_GPIO_OFS = 8'h04;
  localparam logic [HOST_ADDR_W-1:0] HOST_STAT_OFS = 8'h08;
  localparam int CTRL_CONVERT_BIT = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam int STAT_DAV_BIT = 0;
  localparam int STAT_GLOBAL_ALARM_N_BIT = 1;
  localparam int STAT_DAV_SEEN_BIT = 2;
  localparam int STAT_GPIO_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // data-valid pulse state
  typedef enum logic [1:0] {
    MDIA_DAV_IDLE = 2'h1,
    MDIA_DAV_PULSE = 2'h2
  } mdia_dav_t;
endpackage
`default_nettype wire

// >>> logic/mdia_if.sv
`default_nettype none
interface mdia_if #(
  parameter int PINS = mdia_pkg::GPIO_PINS
);
  logic data_valid_n;
  logic global_alarm_n;
  logic convert;
  logic ext_dac_load;
  logic [PINS-1:0] dev_gpio_o;
  logic [PINS-1:0] dev_gpio_oe;
  logic [PINS-1:0] host_gpio_o;
  logic [PINS-1:0] host_gpio_oe;
  wire logic [PINS-1:0] gpio_level;
  // open-drain wire with pull-up: low while any enabled driver drives low
  assign gpio_level = ~((dev_gpio_oe & ~dev_gpio_o) | (host_gpio_oe & ~host_gpio_o));
  modport device (
    output data_valid_n,
    output global_alarm_n,
    output dev_gpio_o,
    output dev_gpio_oe,
    input convert,
    input ext_dac_load,
    input gpio_level
  );
  modport host (
    input data_valid_n,
    input global_alarm_n,
    output convert,
    output ext_dac_load,
    output host_gpio_o,
    output host_gpio_oe,
    input gpio_level
  );
endinterface
`default_nettype wire

// >>> logic/mdia_host.sv
`default_nettype none
module mdia_host #(
  parameter int PINS = mdia_pkg::GPIO_PINS,
  parameter int AW = mdia_pkg::HOST_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  mdia_if.host link
);
  if (AW < 4 || PINS > 8) begin : g_chk
    $error("address too narrow or too many pins");
  end

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [AW-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic convert_reg, load_reg;
  logic [PINS-1:0] pull_reg;
  logic [1:0] dav_sync_reg, global_alarm_n_sync_reg;
  logic [PINS-1:0] gpio_s1_reg, gpio_s2_reg;
  logic dav_prev_reg, dav_seen_reg;

  function automatic logic addr_known(input logic [AW-1:0] a);
    if (a == mdia_pkg::HOST_CTRL_OFS) begin
      addr_known = 1'b1;
    end else if (a == mdia_pkg::HOST_GPIO_OFS) begin
      addr_known = 1'b1;
    end else if (a == mdia_pkg::HOST_STAT_OFS) begin
      addr_known = 1'b1;
    end else begin
      addr_known = 1'b0;
    end
  endfunction

  wire aw_fire = s_axi_awvalid & awready_reg;
  wire w_fire = s_axi_wvalid & wready_reg;
  wire ar_fire = s_axi_arvalid & arready_reg;
  wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire wr_lo = do_write & w_lane_reg;
  wire wr_ctrl = wr_lo & (aw_addr_reg == mdia_pkg::HOST_CTRL_OFS);
  wire wr_gpio = wr_lo & (aw_addr_reg == mdia_pkg::HOST_GPIO_OFS);
  wire wr_stat = wr_lo & (aw_addr_reg == mdia_pkg::HOST_STAT_OFS);
  wire dav_fall = dav_prev_reg & ~dav_sync_reg[1];
  // a falling edge in the clearing cycle keeps the flag
  wire dav_seen_next = dav_fall |
    (dav_seen_reg & ~(wr_stat & w_byte_reg[mdia_pkg::STAT_DAV_SEEN_BIT]));
  wire [31:0] stat_word = (32'(gpio_s2_reg) << mdia_pkg::STAT_GPIO_LSB) |
    (32'(dav_seen_reg) << mdia_pkg::STAT_DAV_SEEN_BIT) |
    (32'(global_alarm_n_sync_reg[1]) << mdia_pkg::STAT_GLOBAL_ALARM_N_BIT) |
    (32'(dav_sync_reg[1]) << mdia_pkg::STAT_DAV_BIT);
  wire [31:0] ctrl_word = (32'(load_reg) << mdia_pkg::CTRL_LOAD_BIT) |
    (32'(convert_reg) << mdia_pkg::CTRL_CONVERT_BIT);
  wire [31:0] rd_word = (s_axi_araddr == mdia_pkg::HOST_CTRL_OFS) ? ctrl_word :
                        (s_axi_araddr == mdia_pkg::HOST_GPIO_OFS) ? 32'(pull_reg) :
                        (s_axi_araddr == mdia_pkg::HOST_STAT_OFS) ? stat_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dav_sync_reg <= 2'h3;
      global_alarm_n_sync_reg <= 2'h3;
      gpio_s1_reg <= '1;
      gpio_s2_reg <= '1;
      dav_prev_reg <= 1'b1;
      dav_seen_reg <= 1'b0;
    end else if (ce) begin
      dav_sync_reg <= {dav_sync_reg[0], link.data_valid_n};
      global_alarm_n_sync_reg <= {global_alarm_n_sync_reg[0], link.global_alarm_n};
      gpio_s1_reg <= link.gpio_level;
      gpio_s2_reg <= gpio_s1_reg;
      dav_prev_reg <= dav_sync_reg[1];
      dav_seen_reg <= dav_seen_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h0;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= mdia_pkg::RESP_OKAY;
      convert_reg <= 1'b0;
      load_reg <= 1'b0;
      pull_reg <= '0;
    end else if (ce) begin
      if (aw_fire) begin
        aw_hold_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_hold_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= addr_known(aw_addr_reg) ? mdia_pkg::RESP_OKAY : mdia_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
      if (wr_ctrl) begin
        convert_reg <= w_byte_reg[mdia_pkg::CTRL_CONVERT_BIT];
        load_reg <= w_byte_reg[mdia_pkg::CTRL_LOAD_BIT];
      end
      if (wr_gpio) begin
        pull_reg <= w_byte_reg[PINS-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= mdia_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= addr_known(s_axi_araddr) ? mdia_pkg::RESP_OKAY : mdia_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign link.convert = convert_reg;
  assign link.ext_dac_load = load_reg;
  assign link.host_gpio_o = '0;
  assign link.host_gpio_oe = pull_reg;
endmodule
`default_nettype wire

// >>> testbench/mdia_checker.sv
`default_nettype none
module mdia_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic data_valid_n,
  input wire logic global_alarm_n,
  input wire logic convert,
  input wire logic ext_dac_load,
  input wire logic [5:0] dev_gpio_oe,
  input wire logic mode_auto,
  input wire logic ext_trigger_en,
  input wire logic group_done,
  input wire logic data_read,
  input wire logic flag_clear,
  input wire logic [7:0] sync_load_en,
  input wire logic conv_start,
  input wire logic conv_done_flag,
  input wire logic [3:0] alarm_flag,
  input wire logic [3:0] pin_function_sel,
  input wire logic [5:0] pin_state_bit,
  input wire logic [7:0] dac_load
);
  localparam int PULSE = mdia_pkg::DAV_PULSE_CYC;
  logic [9:0] low_cnt;
  wire logic auto_run = mode_auto && !ext_trigger_en;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // length of the current low stretch on data valid
  always_ff @(posedge aclk) begin
    if (!aresetn || data_valid_n) begin
      low_cnt <= 10'h000;
    end else begin
      low_cnt <= low_cnt + 10'h001;
    end
  end
  global_alarm_n_follow_a: assert property (global_alarm_n == !(|alarm_flag))
    else $error("global alarm does not follow flags");
  alarm_pin_a: assert property ($stable(alarm_flag) && $stable(pin_function_sel) |->
    ((dev_gpio_oe[3:0] ^ alarm_flag) & ~pin_function_sel) == 4'h0)
    else $error("alarm pin drive wrong");
  readback_a: assert property ($stable(alarm_flag) && $stable(pin_function_sel) |->
    ((pin_state_bit[3:0] ^ ~$past(alarm_flag)) & ~$past(pin_function_sel)) == 4'h0)
    else $error("alarm state readback wrong");
  direct_done_a: assert property (group_done && (!mode_auto || ext_trigger_en) |=>
    conv_done_flag && !data_valid_n)
    else $error("direct pass did not raise done");
  auto_start_a: assert property (group_done && auto_run |=> !data_valid_n && !conv_done_flag)
    else $error("auto pass did not pulse");
  auto_width_a: assert property ($rose(data_valid_n) && auto_run |-> low_cnt == 10'(PULSE))
    else $error("valid pulse width wrong");
  flag_clear_a: assert property ((data_read || flag_clear) && !group_done |=>
    !conv_done_flag)
    else $error("done flag not cleared");
  dac_load_a: assert property ($rose(ext_dac_load) |-> ##[2:5] dac_load == sync_load_en)
    else $error("dac load mask wrong");
  ext_start_a: assert property ($rose(convert) && ext_trigger_en |-> ##[2:5] conv_start)
    else $error("external convert did not start");
endmodule
`default_nettype wire

// >>> testbench/monitor_digital_io_alarm_tb_top.sv
`default_nettype none
module monitor_digital_io_alarm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, soft_reset = 1'b0, mode_auto = 1'b0;
  logic ext_trigger_en = 1'b0, start_cmd = 1'b0, res_valid = 1'b0, group_done = 1'b0;
  logic data_read = 1'b0, flag_clear = 1'b0, gpio_wr = 1'b0;
  logic [3:0] res_pos = 4'h0, wr_function_sel = 4'hf, alarm_flag, pin_function_sel;
  logic [11:0] res_data = 12'h000;
  logic [47:0] upper_bound_reg = 48'h0, lower_bound = 48'h0;
  logic [5:0] wr_state = 6'h3f, pin_state_bit;
  logic [7:0] sync_load_en = 8'h00, awaddr = 8'h00, araddr = 8'h00, dac_load;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done_flag;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [7:0] dq[$];
  int err_count = 0, samples_checked = 0, cs_count = 0, seed = 32'hdcbe9c81;
  mdia_if link ();
  mdia_device mdia_device_inst (
    .aclk, .aresetn, .ce(1'b1), .link(link), .soft_reset, .mode_auto, .ext_trigger_en,
    .start_cmd, .res_valid, .res_pos, .res_data, .group_done, .upper_bound_reg, .lower_bound,
    .data_read, .flag_clear, .gpio_wr, .wr_function_sel, .wr_state, .sync_load_en,
    .conv_start, .conv_done_flag, .alarm_flag, .pin_function_sel, .pin_state_bit, .dac_load
  );
  mdia_host mdia_host_inst (
    .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link)
  );
  mdia_checker mdia_checker_inst (
    .aclk, .aresetn, .data_valid_n(link.data_valid_n), .global_alarm_n(link.global_alarm_n),
    .convert(link.convert), .ext_dac_load(link.ext_dac_load), .dev_gpio_oe(link.dev_gpio_oe),
    .mode_auto, .ext_trigger_en, .group_done, .data_read, .flag_clear, .sync_load_en,
    .conv_start, .conv_done_flag, .alarm_flag, .pin_function_sel, .pin_state_bit, .dac_load
  );
  always #2 aclk = ~aclk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic timeout(input string what);
    err_count++;
    $display("wrong value %s: expected handshake, seen none", what);
    results();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        check("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        return;
      end
    end
    timeout("write");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    rq.push_back({er, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        return;
      end
    end
    timeout("read");
  endtask
  // one sequencer pass over k positions, expected alarms worked out here
  task automatic run_pass(input int k, output logic [3:0] exp);
    logic [11:0] d;
    exp = 4'h0;
    @(posedge aclk) start_cmd <= 1'b1;
    @(posedge aclk) start_cmd <= 1'b0;
    for (int i = 0; i < k; i++) begin
      d = 12'($random(seed));
      if (i < 4 && (d > upper_bound_reg[i*12+:12] || d < lower_bound[i*12+:12])) exp[i] = 1'b1;
      @(posedge aclk);
      res_valid <= 1'b1;
      res_pos <= 4'(i);
      res_data <= d;
    end
    @(posedge aclk);
    res_valid <= 1'b0;
    group_done <= 1'b1;
    @(posedge aclk) group_done <= 1'b0;
    tick(3);
  endtask
  always @(posedge aclk) begin
    if (conv_start) cs_count++;
    if (rvalid && rready) begin
      if (rq.size() == 0) rq.push_back(34'h0);
      check("rdata", rq[0][31:0], rdata);
      check("rresp", {30'h0, rq[0][33:32]}, {30'h0, rresp});
      void'(rq.pop_front());
    end
    if (dac_load != 8'h00) begin
      if (dq.size() == 0) dq.push_back(8'h00);
      check("dac_load", {24'h0, dq.pop_front()}, {24'h0, dac_load});
    end
  end
  initial begin
    logic [3:0] e;
    logic [7:0] s, r;
    logic [5:0] lvl;
    int n;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    check("function_sel", 32'hf, {28'h0, pin_function_sel});
    check("pin_state_bit", 32'h3f, {26'h0, pin_state_bit});
    check("alarm_flag", 32'h0, {28'h0, alarm_flag});
    check("pin_oe", 32'h0, {26'h0, link.dev_gpio_oe});
    axi_rd(8'h08, 32'h3f03, 2'h0);
    axi_rd(8'h0c, 32'h0, 2'h2);
    axi_wr(8'h0c, 32'h1, 2'h2);
    $display("test reset done");
    for (int j = 0; j < 4; j++) begin
      s = 8'($random(seed));
      r = 8'($random(seed));
      @(posedge aclk);
      gpio_wr <= 1'b1;
      wr_state <= s[5:0];
      @(posedge aclk) gpio_wr <= 1'b0;
      axi_wr(8'h04, {26'h0, r[5:0]}, 2'h0);
      tick(4);
      lvl = s[5:0] & ~r[5:0];
      check("pin_state_bit", {26'h0, lvl}, {26'h0, pin_state_bit});
      axi_rd(8'h08, {18'h0, lvl, 8'h03}, 2'h0);
    end
    axi_wr(8'h04, 32'h0, 2'h0);
    $display("test gpio done");
    @(posedge aclk);
    gpio_wr <= 1'b1;
    wr_function_sel <= 4'h0;
    wr_state <= 6'h3f;
    @(posedge aclk) gpio_wr <= 1'b0;
    for (int j = 0; j < 8; j++) begin
      @(posedge aclk);
      upper_bound_reg <= 48'({$random(seed), $random(seed)});
      lower_bound <= 48'({$random(seed), $random(seed)});
      run_pass(1 + j % 6, e);
      check("alarm_flag", {28'h0, e}, {28'h0, alarm_flag});
      check("done_flag", 32'h1, {31'h0, conv_done_flag});
      check("data_valid_n", 32'h0, {31'h0, link.data_valid_n});
      check("global_alarm_n", {31'h0, ~|e}, {31'h0, link.global_alarm_n});
      check("pins", {26'h0, 2'b11, ~e}, {26'h0, link.gpio_level});
      check("alarm_state", {28'h0, ~e}, {28'h0, pin_state_bit[3:0]});
      @(posedge aclk);
      data_read <= j[0];
      flag_clear <= !j[0];
      @(posedge aclk);
      data_read <= 1'b0;
      flag_clear <= 1'b0;
      tick(2);
      check("done_flag", 32'h0, {31'h0, conv_done_flag});
    end
    axi_rd(8'h08, {18'h0, 2'b11, ~e, 5'h0, 1'b1, ~|e, 1'b1}, 2'h0);
    axi_wr(8'h08, 32'h4, 2'h0);
    axi_rd(8'h08, {18'h0, 2'b11, ~e, 5'h0, 1'b0, ~|e, 1'b1}, 2'h0);
    $display("test direct done");
    @(posedge aclk) mode_auto <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      if (j == 1) begin
        upper_bound_reg <= 48'hffffffffffff;
        lower_bound <= 48'h0;
      end
      run_pass(4, e);
      check("data_valid_n", 32'h0, {31'h0, link.data_valid_n});
      check("done_flag", 32'h0, {31'h0, conv_done_flag});
      check("alarm_flag", {28'h0, e}, {28'h0, alarm_flag});
      tick(mdia_pkg::DAV_PULSE_CYC);
      check("data_valid_n", 32'h1, {31'h0, link.data_valid_n});
      check("alarm_flag", {28'h0, e}, {28'h0, alarm_flag});
      if (j == 1) check("global_alarm_n", 32'h1, {31'h0, link.global_alarm_n});
    end
    $display("test auto done");
    @(posedge aclk);
    mode_auto <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge aclk) soft_reset <= 1'b0;
    tick(5);
    check("alarm_flag", 32'h0, {28'h0, alarm_flag});
    check("function_sel", 32'hf, {28'h0, pin_function_sel});
    check("pin_state_bit", 32'h3f, {26'h0, pin_state_bit});
    $display("test soft reset done");
    @(posedge aclk) ext_trigger_en <= 1'b1;
    n = cs_count;
    axi_wr(8'h00, 32'h1, 2'h0);
    axi_wr(8'h00, 32'h0, 2'h0);
    @(posedge aclk) start_cmd <= 1'b1;
    @(posedge aclk) start_cmd <= 1'b0;
    tick(6);
    check("conv_starts", n + 1, cs_count);
    for (int j = 0; j < 3; j++) begin
      s = 8'($random(seed)) | 8'h01;
      @(posedge aclk) sync_load_en <= s;
      dq.push_back(s);
      axi_wr(8'h00, 32'h2, 2'h0);
      axi_wr(8'h00, 32'h0, 2'h0);
      tick(6);
    end
    check("loads_left", 32'h0, dq.size());
    $display("test trigger done");
    results();
  end
endmodule
`default_nettype wire
